// *** hdl/msidm_top.v ***
// Operation
// - Nonzero edge select enters speed mode
// - Tacho mux routes one selected input
// - Rising, falling or both edges capture
// - Preloads load at commutation or directly
// - Encoder clock from all A and B edges
// - Read-only direction sampled at A falling
// - Single encoder input gives half rate
// - Position sensor reserves the selected input
// - Sensorless: analog input, others off/grounded
// - Encoder pin release frees inputs A and B
// - Speed mode: comparator off, digital inputs
// - Eight-bit shifting timer with prescaler
// - Cascaded captures plus demag register
// - Multiplier computes next commutation compare
// - Autoswitched mode commutates in hardware
// - Soft commutation needs compare write first
// - Speed mode never drives six-step
// - Switched compare match commutates, resets timer
`timescale 1ns/10ps
`default_nettype none
`include "msidm_consts.vh"

module msidm_top (
  input wire core_clk_i,
  input wire nrst_i,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire motor_input_a_i,
  input wire motor_input_b_i,
  input wire motor_input_c_i,
  input wire zero_cross_event_i,
  output reg [5:0] pin_mode_o,
  output reg off_input_ground_o,
  output reg phase_comp_on_o,
  output reg commutation_o,
  output reg capture_event_o,
  output reg encoder_clk_o,
  output reg encoder_direction_o
);

  reg [1:0] tacho_edge_sel_reg, input_select_reg, sampling_control_reg;
  reg [1:0] input_select_pre_reg;
  reg [4:0] control_reg_a;
  reg soft_comm_reg, ovf_flag_reg, comm_flag_reg, cap_flag_reg, cmp_armed_reg;
  reg mult_pend_reg;
  reg [7:0] step_timer_reg, zero_cross_capture_reg, zero_cross_previous_reg;
  reg [7:0] demag_reg, comm_cmp_reg, weight_reg;
  reg [3:0] presc_reg;
  reg [15:0] presc_cnt_reg;
  reg [31:0] rdata_next;
  reg [5:0] pin_mode_next;
  wire cap_pulse, enc_clk, enc_dir, speed_mode, auto_mode, tmr_en, tick, acc;
  wire wr, comm_match, hw_zero, sim_zero, cmp_wr, auto_ovf;
  wire [15:0] product;
  wire [7:0] mult_src;

  // ----------------------------------------------------------------
  // Input stage
  // ----------------------------------------------------------------
  msidm_input_stage u_in (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .motor_inputs_i({motor_input_c_i, motor_input_b_i, motor_input_a_i}),
    .tacho_edge_sel_i(tacho_edge_sel_reg), .input_select_i(input_select_reg),
    .capture_pulse_o(cap_pulse), .encoder_clk_o(enc_clk),
    .encoder_direction_o(enc_dir)
  );

  // Mode and access decode.
  assign speed_mode = (tacho_edge_sel_reg != `MSIDM_TES_OFF);
  assign auto_mode = control_reg_a[`MSIDM_CA_AUTO_SW];
  assign tmr_en = control_reg_a[`MSIDM_CA_TMR_EN];
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign cmp_wr = wr && (paddr == `MSIDM_OFS_COMM_CMP);
  assign sim_zero = wr && (paddr == `MSIDM_OFS_ZC_CAP);
  assign hw_zero = zero_cross_event_i & auto_mode & ~speed_mode;
  assign tick = tmr_en &&
    (presc_cnt_reg == ((16'h0001 << presc_reg) - 16'h0001));
  assign auto_ovf = tick && auto_mode && !speed_mode &&
    (step_timer_reg == `MSIDM_TMR_MAX);
  assign mult_src = control_reg_a[`MSIDM_CA_USE_CAP] ?
    zero_cross_capture_reg : zero_cross_previous_reg;
  assign product = weight_reg * mult_src;
  assign comm_match = cmp_armed_reg && tmr_en && !speed_mode &&
    (step_timer_reg >= comm_cmp_reg);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // Read data mux for the setup cycle.
  always @* begin
    rdata_next = 32'h00000000;
    case (paddr)
      `MSIDM_OFS_EDGE_CFG: rdata_next[1:0] = tacho_edge_sel_reg;
      `MSIDM_OFS_PHASE_ST:
        rdata_next[3:0] = {input_select_pre_reg, input_select_reg};
      `MSIDM_OFS_CTRL_A: rdata_next[4:0] = control_reg_a;
      `MSIDM_OFS_CTRL_C:
        rdata_next[5:0] = {cap_flag_reg, comm_flag_reg, phase_comp_on_o,
                           ovf_flag_reg, enc_dir, soft_comm_reg};
      `MSIDM_OFS_SAMPLING: rdata_next[1:0] = sampling_control_reg;
      `MSIDM_OFS_STEP_TMR: rdata_next[7:0] = step_timer_reg;
      `MSIDM_OFS_ZC_CAP: rdata_next[7:0] = zero_cross_capture_reg;
      `MSIDM_OFS_ZC_PREV: rdata_next[7:0] = zero_cross_previous_reg;
      `MSIDM_OFS_DEMAG: rdata_next[7:0] = demag_reg;
      `MSIDM_OFS_COMM_CMP: rdata_next[7:0] = comm_cmp_reg;
      `MSIDM_OFS_WEIGHT: rdata_next[7:0] = weight_reg;
      `MSIDM_OFS_PRESC: rdata_next[3:0] = presc_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // No wait state: answer is prepared in setup, given in the first access cycle.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= rdata_next;
      pready <= 1'b1;
      pslverr <= (paddr[1:0] != 2'h0) || (paddr > `MSIDM_OFS_PRESC);
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  // Software-written control and preload fields.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tacho_edge_sel_reg <= `MSIDM_TES_OFF;
      input_select_reg <= 2'h0;
      input_select_pre_reg <= 2'h0;
      control_reg_a <= 5'h00;
      soft_comm_reg <= 1'b0;
      sampling_control_reg <= 2'h0;
      weight_reg <= `MSIDM_RST_BYTE;
      presc_reg <= 4'h0;
    end else begin
      if (wr && !pslverr) begin
        case (paddr)
          `MSIDM_OFS_EDGE_CFG: tacho_edge_sel_reg <= pwdata[1:0];
          `MSIDM_OFS_PHASE_ST: input_select_pre_reg <= pwdata[1:0];
          `MSIDM_OFS_CTRL_A: control_reg_a <= pwdata[4:0];
          `MSIDM_OFS_CTRL_C: soft_comm_reg <= pwdata[`MSIDM_CC_SOFT_COMM];
          `MSIDM_OFS_SAMPLING: sampling_control_reg <= pwdata[1:0];
          `MSIDM_OFS_WEIGHT: weight_reg <= pwdata[7:0];
          `MSIDM_OFS_PRESC: begin
            if (!tmr_en) begin
              presc_reg <= pwdata[3:0];
            end
          end
          default: begin
          end
        endcase
      end
      if (wr && paddr == `MSIDM_OFS_PHASE_ST &&
          control_reg_a[`MSIDM_CA_DIRECT_LOAD]) begin
        input_select_reg <= pwdata[1:0];
      end else if (commutation_o) begin
        input_select_reg <= input_select_pre_reg;
      end
      if (auto_ovf && presc_reg != `MSIDM_PRESC_MAX) begin
        presc_reg <= presc_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Delay manager
  // ----------------------------------------------------------------
  // Step timer, captures, compare and commutation.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      presc_cnt_reg <= 16'h0000;
      step_timer_reg <= `MSIDM_RST_BYTE;
      zero_cross_capture_reg <= `MSIDM_RST_BYTE;
      zero_cross_previous_reg <= `MSIDM_RST_BYTE;
      demag_reg <= `MSIDM_RST_BYTE;
      comm_cmp_reg <= `MSIDM_RST_BYTE;
      cmp_armed_reg <= 1'b0;
      mult_pend_reg <= 1'b0;
      commutation_o <= 1'b0;
      ovf_flag_reg <= 1'b0;
      comm_flag_reg <= 1'b0;
      cap_flag_reg <= 1'b0;
    end else begin
      commutation_o <= 1'b0;
      mult_pend_reg <= 1'b0;
      // Write one to clear; a same-cycle event wins below.
      if (wr && paddr == `MSIDM_OFS_CTRL_C) begin
        if (pwdata[`MSIDM_CC_OVF]) ovf_flag_reg <= 1'b0;
        if (pwdata[`MSIDM_CC_COMM_FLAG]) comm_flag_reg <= 1'b0;
        if (pwdata[`MSIDM_CC_CAP_FLAG]) cap_flag_reg <= 1'b0;
      end
      if (wr && paddr == `MSIDM_OFS_DEMAG) begin
        demag_reg <= pwdata[7:0];
      end
      if (tmr_en) begin
        presc_cnt_reg <= tick ? 16'h0000 : presc_cnt_reg + 16'h0001;
      end else begin
        presc_cnt_reg <= 16'h0000;
      end
      if (tick) begin
        step_timer_reg <= step_timer_reg + 8'h01;
        if (step_timer_reg == `MSIDM_TMR_MAX &&
            tacho_edge_sel_reg == `MSIDM_TES_OFF) begin
          ovf_flag_reg <= 1'b1;
        end
      end
      if (auto_ovf) begin
        step_timer_reg <= `MSIDM_TMR_MID;
        zero_cross_capture_reg <= {1'b0, zero_cross_capture_reg[7:1]};
        zero_cross_previous_reg <= {1'b0, zero_cross_previous_reg[7:1]};
        demag_reg <= {1'b0, demag_reg[7:1]};
        comm_cmp_reg <= {1'b0, comm_cmp_reg[7:1]};
        mult_pend_reg <= ~soft_comm_reg;
      end
      if (hw_zero || (speed_mode && cap_pulse)) begin
        zero_cross_capture_reg <= step_timer_reg;
        zero_cross_previous_reg <= zero_cross_capture_reg;
        step_timer_reg <= `MSIDM_RST_BYTE;
        cap_flag_reg <= 1'b1;
        mult_pend_reg <= auto_mode & ~soft_comm_reg & ~speed_mode;
      end else if (sim_zero) begin
        zero_cross_capture_reg <= pwdata[7:0];
        zero_cross_previous_reg <= pwdata[7:0];
        step_timer_reg <= `MSIDM_RST_BYTE;
        mult_pend_reg <= auto_mode & ~soft_comm_reg;
      end
      if (cmp_wr && (soft_comm_reg || !auto_mode)) begin
        comm_cmp_reg <= pwdata[7:0];
        cmp_armed_reg <= 1'b1;
      end else if (mult_pend_reg && auto_mode && !soft_comm_reg) begin
        comm_cmp_reg <= product[15:8];
        cmp_armed_reg <= 1'b1;
      end else if (comm_match) begin
        commutation_o <= 1'b1;
        comm_flag_reg <= 1'b1;
        cmp_armed_reg <= !auto_mode && !soft_comm_reg;
        if (auto_mode) begin
          comm_cmp_reg <= step_timer_reg;
        end else if (!hw_zero && !sim_zero) begin
          step_timer_reg <= `MSIDM_RST_BYTE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin configuration
  // ----------------------------------------------------------------
  // Per-pin mode from release, edge, sensor and select fields.
  always @* begin
    pin_mode_next = {3{`MSIDM_PIN_STD}};
    if (speed_mode) begin
      if (input_select_reg == `MSIDM_IS_ENCODER) begin
        if (!sampling_control_reg[`MSIDM_SC_PIN_REL]) begin
          pin_mode_next = {`MSIDM_PIN_STD, `MSIDM_PIN_DIGITAL,
                           `MSIDM_PIN_DIGITAL};
        end
      end else begin
        pin_mode_next[input_select_reg*2 +: 2] = `MSIDM_PIN_DIGITAL;
      end
    end else if (input_select_reg != `MSIDM_IS_ENCODER) begin
      if (control_reg_a[`MSIDM_CA_POS_SENS]) begin
        pin_mode_next[input_select_reg*2 +: 2] = `MSIDM_PIN_ANALOG;
      end else begin
        pin_mode_next = {3{`MSIDM_PIN_OFF}};
        pin_mode_next[input_select_reg*2 +: 2] = `MSIDM_PIN_ANALOG;
      end
    end else if (!control_reg_a[`MSIDM_CA_POS_SENS]) begin
      pin_mode_next = {3{`MSIDM_PIN_OFF}};
    end
  end

  // Registered pin, comparator and event outputs.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_mode_o <= 6'h00;
      off_input_ground_o <= 1'b0;
      phase_comp_on_o <= 1'b0;
      capture_event_o <= 1'b0;
      encoder_clk_o <= 1'b0;
      encoder_direction_o <= 1'b0;
    end else begin
      pin_mode_o <= pin_mode_next;
      off_input_ground_o <= sampling_control_reg[`MSIDM_SC_OFF_GND] &
        ~speed_mode & ~control_reg_a[`MSIDM_CA_POS_SENS];
      phase_comp_on_o <= ~speed_mode;
      capture_event_o <= cap_pulse;
      encoder_clk_o <= enc_clk;
      encoder_direction_o <= enc_dir;
    end
  end

endmodule

`default_nettype wire

// *** hdl/msidm_consts.vh ***
`ifndef MSIDM_CONSTS_VH
`define MSIDM_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define MSIDM_OFS_EDGE_CFG 8'h00
`define MSIDM_OFS_PHASE_ST 8'h04
`define MSIDM_OFS_CTRL_A 8'h08
`define MSIDM_OFS_CTRL_C 8'h0C
`define MSIDM_OFS_SAMPLING 8'h10
`define MSIDM_OFS_STEP_TMR 8'h14
`define MSIDM_OFS_ZC_CAP 8'h18
`define MSIDM_OFS_ZC_PREV 8'h1C
`define MSIDM_OFS_DEMAG 8'h20
`define MSIDM_OFS_COMM_CMP 8'h24
`define MSIDM_OFS_WEIGHT 8'h28
`define MSIDM_OFS_PRESC 8'h2C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MSIDM_CA_POS_SENS 0
`define MSIDM_CA_DIRECT_LOAD 1
`define MSIDM_CA_AUTO_SW 2
`define MSIDM_CA_TMR_EN 3
`define MSIDM_CA_USE_CAP 4
`define MSIDM_CC_SOFT_COMM 0
`define MSIDM_CC_ENC_DIR 1
`define MSIDM_CC_OVF 2
`define MSIDM_CC_PHASE_COMP 3
`define MSIDM_CC_COMM_FLAG 4
`define MSIDM_CC_CAP_FLAG 5
`define MSIDM_SC_OFF_GND 0
`define MSIDM_SC_PIN_REL 1

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define MSIDM_TES_OFF 2'h0
`define MSIDM_TES_RISE 2'h1
`define MSIDM_TES_FALL 2'h2
`define MSIDM_TES_BOTH 2'h3
`define MSIDM_IS_ENCODER 2'h3
`define MSIDM_PIN_STD 2'h0
`define MSIDM_PIN_ANALOG 2'h1
`define MSIDM_PIN_DIGITAL 2'h2
`define MSIDM_PIN_OFF 2'h3
`define MSIDM_TMR_MAX 8'hFF
`define MSIDM_TMR_MID 8'h80
`define MSIDM_PRESC_MAX 4'hF
`define MSIDM_RST_BYTE 8'h00

`endif

// *** hdl/msidm_input_stage.v ***
`timescale 1ns/10ps
`default_nettype none

// Synchronises the motor inputs, detects tacho edges and decodes the
// quadrature encoder.
module msidm_input_stage (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [2:0] motor_inputs_i,
  input wire [1:0] tacho_edge_sel_i,
  input wire [1:0] input_select_i,
  output reg capture_pulse_o,
  output reg encoder_clk_o,
  output reg encoder_direction_o
);

  reg [2:0] sync1_reg;
  reg [2:0] sync2_reg;
  reg [2:0] last_reg;
  wire [2:0] rise;
  wire [2:0] fall;
  wire tacho_rise;
  wire tacho_fall;
  wire speed_mode;
  wire encoder_mode;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
          last_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= motor_inputs_i[gi];
          sync2_reg[gi] <= sync1_reg[gi];
          last_reg[gi] <= sync2_reg[gi];
        end
      end
      assign rise[gi] = sync2_reg[gi] & ~last_reg[gi];
      assign fall[gi] = ~sync2_reg[gi] & last_reg[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Edge selection
  // ----------------------------------------------------------------
  // speed mode decode.
  assign speed_mode = (tacho_edge_sel_i != `MSIDM_TES_OFF);
  assign encoder_mode = speed_mode & (input_select_i == `MSIDM_IS_ENCODER);
  assign tacho_rise = (input_select_i == 2'h0) ? rise[0] :
                      (input_select_i == 2'h1) ? rise[1] : rise[2];
  assign tacho_fall = (input_select_i == 2'h0) ? fall[0] :
                      (input_select_i == 2'h1) ? fall[1] : fall[2];

  // Capture pulses and encoder clock, one cycle wide; direction held.
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      capture_pulse_o <= 1'b0;
      encoder_clk_o <= 1'b0;
      encoder_direction_o <= 1'b0;
    end else begin
      capture_pulse_o <= 1'b0;
      encoder_clk_o <= 1'b0;
      if (speed_mode && !encoder_mode) begin
        case (tacho_edge_sel_i)
          `MSIDM_TES_RISE: capture_pulse_o <= tacho_rise;
          `MSIDM_TES_FALL: capture_pulse_o <= tacho_fall;
          `MSIDM_TES_BOTH: capture_pulse_o <= tacho_rise | tacho_fall;
          default: capture_pulse_o <= 1'b0;
        endcase
      end
      if (encoder_mode) begin
        encoder_clk_o <= rise[0] | fall[0] | rise[1] | fall[1];
        if (fall[0]) begin
          encoder_direction_o <= sync2_reg[1];
        end
      end
    end
  end

endmodule

`default_nettype wire

// *** verification/msidm_motor_model.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Sensor side: tacho, hall or encoder.
// ----------------------------------------
module msidm_motor_model (
  input wire logic core_clk_i,
  output logic [2:0] pins_o,
  output logic zero_cross_o
);
  // Pins and the back-EMF zero-cross output start low.
  initial begin
    pins_o = 3'h0;
    zero_cross_o = 1'b0;
  end

  // Keeps every level for three cycles, above the synchroniser minimum.
  task hold;
    repeat (3) @(posedge core_clk_i);
  endtask

  // One pulse on one pin, as a tacho or hall output gives.
  task pulse(input int p);
    pins_o[p] <= 1'b1;
    hold();
    pins_o[p] <= 1'b0;
    hold();
  endtask

  task quad(input int n, input logic fwd);
    for (int i = 0; i < 4 * n; i++) begin
      if ((i % 2 == 0) == fwd) pins_o[0] <= ~pins_o[0];
      else pins_o[1] <= ~pins_o[1];
      hold();
    end
  endtask

  // One back-EMF zero-crossing pulse, a single cycle wide.
  task zc_pulse;
    zero_cross_o <= 1'b1;
    @(posedge core_clk_i);
    zero_cross_o <= 1'b0;
  endtask

  // An encoder with only its first output wired.
  task solo(input int n);
    repeat (2 * n) begin
      pins_o[0] <= ~pins_o[0];
      hold();
    end
  endtask
endmodule
`default_nettype wire

// *** verification/msidm_top_asserts.sv ***
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Mode and event pulse relations.
// ----------------------------------------
module msidm_top_chk (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic motor_input_a_i,
  input wire logic motor_input_b_i,
  input wire logic [5:0] pin_mode_o,
  input wire logic off_input_ground_o,
  input wire logic phase_comp_on_o,
  input wire logic commutation_o,
  input wire logic capture_event_o,
  input wire logic encoder_clk_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  cap_speed_a: assert property (capture_event_o |-> !phase_comp_on_o)
    else $error("capture with comparator on");
  enc_speed_a: assert property (encoder_clk_o |-> !phase_comp_on_o)
    else $error("encoder clock outside speed mode");
  speed_pins_a: assert property (
    !phase_comp_on_o |-> pin_mode_o[1:0] != 2'h1 &&
    pin_mode_o[3:2] != 2'h1 && pin_mode_o[5:4] != 2'h1)
    else $error("analog pin in speed mode");
  gnd_mode_a: assert property (off_input_ground_o |-> phase_comp_on_o)
    else $error("grounding outside sensorless");
  no_six_a: assert property (
    commutation_o |-> phase_comp_on_o || $past(phase_comp_on_o))
    else $error("commutation in speed mode");
  cap_one_a: assert property (capture_event_o |=> !capture_event_o)
    else $error("capture pulse too long");
  enc_one_a: assert property (encoder_clk_o |=> !encoder_clk_o)
    else $error("encoder pulse too long");
  comm_one_a: assert property (commutation_o |=> !commutation_o)
    else $error("commutation pulse too long");
  enc_lat_a: assert property (
    encoder_clk_o |-> $past(motor_input_a_i, 4) != $past(motor_input_a_i, 5)
    || $past(motor_input_b_i, 4) != $past(motor_input_b_i, 5))
    else $error("encoder clock without pin edge");

  cover property (capture_event_o);
  cover property (encoder_clk_o);
  cover property (commutation_o);
endmodule

bind msidm_top msidm_top_chk i_chk (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i),
  .motor_input_a_i(motor_input_a_i), .motor_input_b_i(motor_input_b_i),
  .pin_mode_o(pin_mode_o), .off_input_ground_o(off_input_ground_o),
  .phase_comp_on_o(phase_comp_on_o), .commutation_o(commutation_o),
  .capture_event_o(capture_event_o), .encoder_clk_o(encoder_clk_o)
);
`default_nettype wire

// *** verification/tb.sv ***
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic core_clk_i, nrst_i, psel, penable, pwrite, pready, pslverr, zc;
  logic cap_o, enc_o, com_o, dir_o, gnd_o, cmp_o;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0] pm;
  logic [2:0] mi;
  int bad_count, check_count, cap_n, enc_n, com_n;

  msidm_top i_dut (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motor_input_a_i(mi[0]), .motor_input_b_i(mi[1]),
    .motor_input_c_i(mi[2]), .zero_cross_event_i(zc), .pin_mode_o(pm),
    .off_input_ground_o(gnd_o), .phase_comp_on_o(cmp_o),
    .commutation_o(com_o), .capture_event_o(cap_o),
    .encoder_clk_o(enc_o), .encoder_direction_o(dir_o)
  );
  msidm_motor_model i_mdl (
    .core_clk_i(core_clk_i), .pins_o(mi), .zero_cross_o(zc)
  );

  // Free-running 20 MHz clock.
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end

  // Counts the single-cycle event pulses.
  always @(posedge core_clk_i) begin
    if (cap_o === 1'b1) cap_n++;
    if (enc_o === 1'b1) enc_n++;
    if (com_o === 1'b1) com_n++;
  end

  // ----------------------------------------
  // Bus and checking helpers.
  // ----------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("unexpected %0t %s", $time, m);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  task rst;
    nrst_i <= 1'b0;
    wt(6);
    nrst_i <= 1'b1;
  endtask

  // One APB transfer; holds the request until pready is sampled high.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_i);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task t_sensorless;
    logic [31:0] r;
    logic e;
    rst();
    wt(2);
    chk(pm === 6'h3D && cmp_o === 1'b1 && gnd_o === 1'b0, "reset");
    apb(1'b0, 8'h30, 32'h0, r, e);
    chk(e === 1'b1 && r === 32'h0, "unmapped read");
    wr(8'h10, 32'h1);
    wr(8'h04, 32'h1);
    wt(2);
    chk(gnd_o === 1'b1, "grounding");
    chk(pm === 6'h3D, "preload held");
    wr(8'h08, 32'h2);
    wr(8'h04, 32'h2);
    wt(2);
    chk(pm === 6'h1F, "direct load");
    wr(8'h08, 32'h3);
    wt(2);
    chk(pm === 6'h10 && gnd_o === 1'b0, "position pins");
  endtask

  task t_tacho;
    for (int t = 1; t < 4; t++) begin
      rst();
      wr(8'h08, 32'h2);
      wr(8'h04, 32'h1);
      wr(8'h00, 32'(t));
      wt(2);
      chk(pm === 6'h08 && cmp_o === 1'b0, "tacho pins");
      cap_n = 0;
      i_mdl.pulse(1);
      i_mdl.pulse(0);
      wt(6);
      chk(cap_n == ((t == 3) ? 2 : 1), "capture count");
    end
  endtask

  task t_encoder;
    logic [31:0] r;
    logic e;
    rst();
    wr(8'h08, 32'h2);
    wr(8'h04, 32'h3);
    wr(8'h00, 32'h1);
    wt(2);
    chk(pm === 6'h0A && cmp_o === 1'b0, "encoder pins");
    enc_n = 0;
    i_mdl.quad(2, 1'b1);
    wt(6);
    chk(enc_n == 8 && dir_o === 1'b1, "forward");
    i_mdl.quad(2, 1'b0);
    wt(6);
    chk(enc_n == 16 && dir_o === 1'b0, "reverse");
    wr(8'h0C, 32'h2);
    apb(1'b0, 8'h0C, 32'h0, r, e);
    chk(r[1] === 1'b0 && dir_o === 1'b0, "direction write");
    i_mdl.solo(2);
    wt(6);
    chk(enc_n == 20, "single input");
    wr(8'h10, 32'h2);
    wt(2);
    chk(pm === 6'h00 && cmp_o === 1'b0, "pins released");
  endtask

  task t_switched;
    logic [31:0] r;
    logic e;
    int n;
    rst();
    wr(8'h0C, 32'h1);
    wr(8'h08, 32'h8);
    com_n = 0;
    wt(100);
    chk(com_n == 0, "no compare write");
    wr(8'h24, 32'h8);
    wt(60);
    chk(com_n == 1, "one soft commutation");
    wr(8'h0C, 32'h0);
    wr(8'h24, 32'h8);
    n = 0;
    while (com_o !== 1'b1 && n < 50) begin
      wt(1);
      n++;
    end
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk(n < 50 && r < 32'h8, "timer restart");
    com_n = 0;
    wt(60);
    chk(com_n > 3, "repeated commutation");
    wr(8'h00, 32'h1);
    wt(2);
    com_n = 0;
    wt(60);
    chk(com_n == 0, "speed mode");
  endtask

  // Autoswitched mode: multiplier, hardware commutation, captures.
  task t_auto;
    logic [31:0] r;
    logic e;
    rst();
    wr(8'h28, 32'h80);
    wr(8'h08, 32'h1C);
    com_n = 0;
    wr(8'h18, 32'h20);
    apb(1'b0, 8'h24, 32'h0, r, e);
    chk(r === 32'h10, "multiplier compare");
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk(r === 32'h20, "simulated zero cross");
    wt(30);
    chk(com_n == 1, "hardware commutation");
    i_mdl.zc_pulse();
    wt(2);
    apb(1'b0, 8'h1C, 32'h0, r, e);
    chk(r === 32'h20, "capture cascade");
    apb(1'b0, 8'h18, 32'h0, r, e);
    chk(r > 32'h20 && r < 32'h30, "timer captured");
  endtask

  // Watchdog against a hung handshake.
  initial begin
    wt(5000);
    bad_count++;
    end_sim();
  end

  // Main sequence.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    t_sensorless();
    t_tacho();
    t_encoder();
    t_switched();
    t_auto();
    end_sim();
  end
endmodule
`default_nettype wire
